//--- exc_params.svh
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define ICS_OFFSET        12'hd04
`define AIRC_OFFSET       12'hd0c
`define EVT_STATUS_OFFSET 12'hd40
`define EVT_MASK_OFFSET   12'hd44

// ==========================================================================
// Interrupt control and state fields
`define SVC_SET_BIT       28
`define SVC_CLR_BIT       27
`define TICK_SET_BIT      26
`define TICK_CLR_BIT      25
`define DBG_FLAG_BIT      23
`define IRQ_FLAG_BIT      22
`define PEND_VEC_LSB      12
`define ACT_VEC_LSB       0

// ==========================================================================
// Reset control fields and values
`define KEY_LSB           16
`define WRITE_KEY         16'h05fa
`define AIRC_RESET        32'hfa050000
`define SYSRST_BIT        2
`define CLRACT_BIT        1

// ==========================================================================
// Exception numbers
`define SVC_EXC_NUM       6'h0e
`define TICK_EXC_NUM      6'h0f
`define IRQ_BASE_NUM      6'h10

// ==========================================================================
// Event status bits
`define EVT_WIDTH         3
`define EVT_TICK          0
`define EVT_SVC           1
`define EVT_BADKEY        2

`endif

//--- exc_pkg.sv
package exc_pkg;

  // Avalon answer phase: one wait cycle, then the answer
  typedef enum logic [0:0] {
    phase_wait   = 1'b0,
    phase_answer = 1'b1
  } bus_phase_type;

endpackage

//--- pending_vector_select.sv
`timescale 1ns/1ps
`include "exc_params.svh"

module pending_vector_select (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Pending sources
  input  wire logic        service_pending,
  input  wire logic        tick_pending,
  input  wire logic [1:0]  service_priority,
  input  wire logic [1:0]  tick_priority,
  input  wire logic [31:0] irq_pending,
  input  wire logic [31:0] irq_enable,
  input  wire logic [63:0] irq_priority,
  // Result
  output logic      [5:0]  pending_vector
);

  logic [33:0] cand_vld;
  logic [1:0]  cand_pri [0:33];
  logic [5:0]  cand_num [0:33];
  logic [34:0] best_vld;
  logic [1:0]  best_pri [0:34];
  logic [5:0]  best_num [0:34];

  assign best_vld[0] = 1'b0;
  assign best_pri[0] = 2'h3;
  assign best_num[0] = 6'h00;

  // ========================================================================
  // Candidates in rising exception number; a strict compare keeps the
  // lower number on equal priority
  genvar g;
  for (g = 0; g < 34; g = g + 1) begin : gen_cand
    if (g == 0) begin : gen_svc
      assign cand_vld[g] = service_pending;
      assign cand_pri[g] = service_priority;
      assign cand_num[g] = `SVC_EXC_NUM;
    end else if (g == 1) begin : gen_tick
      assign cand_vld[g] = tick_pending;
      assign cand_pri[g] = tick_priority;
      assign cand_num[g] = `TICK_EXC_NUM;
    end else begin : gen_irq
      assign cand_vld[g] = irq_pending[g-2] & irq_enable[g-2];
      assign cand_pri[g] = irq_priority[2*(g-2) +: 2];
      assign cand_num[g] = `IRQ_BASE_NUM + 6'(g-2);
    end
    logic take;
    assign take = cand_vld[g] & (~best_vld[g] | (cand_pri[g] < best_pri[g]));
    assign best_vld[g+1] = best_vld[g] | cand_vld[g];
    assign best_pri[g+1] = take ? cand_pri[g] : best_pri[g];
    assign best_num[g+1] = take ? cand_num[g] : best_num[g];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending_vector <= 6'h00;
    end else begin
      pending_vector <= best_vld[34] ? best_num[34] : 6'h00;
    end
  end

endmodule // pending_vector_select

//--- exception_state_reset_ctrl.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "exc_params.svh"


module exception_state_reset_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Core side
  input  wire logic        tick_event,
  input  wire logic        exc_entry,
  input  wire logic [5:0]  exc_entry_number,
  input  wire logic        core_halted,
  input  wire logic [5:0]  core_active_vector,
  input  wire logic [31:0] ext_irq_pending,
  input  wire logic [31:0] ext_irq_enable,
  input  wire logic [63:0] ext_irq_priority,
  input  wire logic [1:0]  tick_priority,
  input  wire logic [1:0]  service_priority,
  // Status and requests
  output logic             tick_pending,
  output logic             service_call_pending,
  output logic      [5:0]  pending_vector_number,
  output logic             system_reset_request,
  output logic             clear_active_state,
  output logic             irq
);

  exc_pkg::bus_phase_type phase;
  logic                   access;
  logic                   do_write;
  logic                   do_read_sample;
  logic                   ics_write;
  logic                   airc_write;
  logic                   key_ok;
  logic                   debug_exit_service_flag;
  logic                   irq_pending_flag;
  logic [`EVT_WIDTH-1:0]  evt_status;
  logic [`EVT_WIDTH-1:0]  evt_mask;
  logic [`EVT_WIDTH-1:0]  evt_set;
  logic                   tick_set_req;
  logic                   svc_set_req;
  logic [31:0]            next_readdata;

  // ==========================================================================
  // Bus handshake: one wait cycle, answer on the second
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & (phase == exc_pkg::phase_wait);
  assign do_write        = avs_write & (phase == exc_pkg::phase_answer);
  assign do_read_sample  = avs_read & (phase == exc_pkg::phase_wait);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= exc_pkg::phase_wait;
    end else begin
      case (phase)
        exc_pkg::phase_wait:   phase <= access ? exc_pkg::phase_answer
                                               : exc_pkg::phase_wait;
        exc_pkg::phase_answer: phase <= exc_pkg::phase_wait;
        default:               phase <= exc_pkg::phase_wait;
      endcase
    end
  end

  // Field bytes must be enabled; ICS checks byte 3 only, AIRC needs all four bytes
  assign ics_write  = do_write & (avs_address == `ICS_OFFSET)
                      & avs_byteenable[3];
  assign key_ok     = avs_writedata[`KEY_LSB +: 16] == `WRITE_KEY;
  // Unkeyed writes are dropped rather than left unpredictable
  assign airc_write = do_write & (avs_address == `AIRC_OFFSET)
                      & (&avs_byteenable) & key_ok;

  // ==========================================================================
  // Pending state
  assign tick_set_req = ics_write & avs_writedata[`TICK_SET_BIT];
  assign svc_set_req  = ics_write & avs_writedata[`SVC_SET_BIT];

  // Setting wins over clearing or entry in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_pending <= 1'b0;
    end else if (tick_set_req | tick_event) begin
      tick_pending <= 1'b1;
    end else if ((ics_write & avs_writedata[`TICK_CLR_BIT])
                 | (exc_entry & (exc_entry_number == `TICK_EXC_NUM))) begin
      tick_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      service_call_pending <= 1'b0;
    end else if (svc_set_req) begin
      service_call_pending <= 1'b1;
    end else if ((ics_write & avs_writedata[`SVC_CLR_BIT])
                 | (exc_entry & (exc_entry_number == `SVC_EXC_NUM))) begin
      service_call_pending <= 1'b0;
    end
  end

  pending_vector_select u_select (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .service_pending  (service_call_pending),
    .tick_pending     (tick_pending),
    .service_priority (service_priority),
    .tick_priority    (tick_priority),
    .irq_pending      (ext_irq_pending),
    .irq_enable       (ext_irq_enable),
    .irq_priority     (ext_irq_priority),
    .pending_vector   (pending_vector_number)
  );

  assign irq_pending_flag = (|ext_irq_pending) | tick_pending
                            | service_call_pending;
  assign debug_exit_service_flag = core_halted
                                   & (pending_vector_number != 6'h00);

  // ==========================================================================
  // Reset request and clear-active
  // Held until the chip reset it triggers clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_request <= 1'b0;
    end else if (airc_write & avs_writedata[`SYSRST_BIT]) begin
      system_reset_request <= 1'b1;
    end
  end

  // Halt check is left to the debugger
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clear_active_state <= 1'b0;
    end else begin
      clear_active_state <= airc_write & avs_writedata[`CLRACT_BIT];
    end
  end

  // ==========================================================================
  // Event interrupt
  always_comb begin
    evt_set              = '0;
    evt_set[`EVT_TICK]   = tick_set_req | tick_event;
    evt_set[`EVT_SVC]    = svc_set_req;
    evt_set[`EVT_BADKEY] = do_write & (avs_address == `AIRC_OFFSET)
                           & ~((&avs_byteenable) & key_ok);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= '0;
    end else if (do_write & (avs_address == `EVT_STATUS_OFFSET)
                 & avs_byteenable[0]) begin
      evt_status <= (evt_status & ~avs_writedata[`EVT_WIDTH-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask <= '0;
    end else if (do_write & (avs_address == `EVT_MASK_OFFSET)
                 & avs_byteenable[0]) begin
      evt_mask <= avs_writedata[`EVT_WIDTH-1:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ==========================================================================
  // Read mux; write-only and reserved bits read zero
  always_comb begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `ICS_OFFSET: begin
        next_readdata[`SVC_SET_BIT]  = service_call_pending;
        next_readdata[`TICK_SET_BIT] = tick_pending;
        next_readdata[`DBG_FLAG_BIT] = debug_exit_service_flag;
        next_readdata[`IRQ_FLAG_BIT] = irq_pending_flag;
        next_readdata[`PEND_VEC_LSB +: 6] = pending_vector_number;
        next_readdata[`ACT_VEC_LSB +: 6]  = core_active_vector;
      end
      `AIRC_OFFSET:       next_readdata = `AIRC_RESET;
      `EVT_STATUS_OFFSET: next_readdata[`EVT_WIDTH-1:0] = evt_status;
      `EVT_MASK_OFFSET:   next_readdata[`EVT_WIDTH-1:0] = evt_mask;
      default:            next_readdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (do_read_sample) begin
      avs_readdata <= next_readdata;
    end
  end

  // ==========================================================================
  // Checks
  a_tick_set_pends: assert property (
    @(posedge mclk) disable iff (!rst_n)
    tick_set_req |=> tick_pending)
    else $error("tick set write did not pend");

  a_tick_clear_works: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ics_write && avs_writedata[`TICK_CLR_BIT] && !tick_set_req
    && !tick_event |=> !tick_pending)
    else $error("tick clear write left it pending");

  a_svc_clear_works: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ics_write && avs_writedata[`SVC_CLR_BIT] && !svc_set_req
    |=> !service_call_pending)
    else $error("service clear write left it pending");

  a_svc_only_sw: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(service_call_pending) |-> $past(svc_set_req))
    else $error("service pended without a set write");

  a_vector_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(|(ext_irq_pending & ext_irq_enable)) && !tick_pending
    && !service_call_pending |=> pending_vector_number == 6'h00)
    else $error("pending vector nonzero with nothing pending");

  a_reset_req_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(system_reset_request) |-> $past(airc_write)
    ##1 system_reset_request [*4])
    else $error("reset request not keyed or not held");

  a_clear_act_pulse: assert property (
    @(posedge mclk) disable iff (!rst_n)
    clear_active_state |-> $past(airc_write) ##1 !clear_active_state)
    else $error("clear active not a single keyed pulse");

  a_airc_readback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    avs_read && !avs_waitrequest && avs_address == `AIRC_OFFSET
    |-> avs_readdata == `AIRC_RESET)
    else $error("reset control read wrong value");

  a_answer_timing: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(access) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  a_tick_zero_write: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ics_write && !avs_writedata[`TICK_SET_BIT]
    && !avs_writedata[`TICK_CLR_BIT] && !tick_event && !exc_entry
    |=> $stable(tick_pending))
    else $error("zero write changed tick pending");

  a_active_readback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address == `ICS_OFFSET
    |=> avs_readdata[`ACT_VEC_LSB +: 6] == $past(core_active_vector))
    else $error("active vector read back wrong");

  a_debug_flag_run: assert property (
    @(posedge mclk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address == `ICS_OFFSET
    && !core_halted |=> !avs_readdata[`DBG_FLAG_BIT])
    else $error("debug exit flag set while running");

  a_irq_flag_read: assert property (
    @(posedge mclk) disable iff (!rst_n)
    avs_read && avs_waitrequest && avs_address == `ICS_OFFSET
    && (tick_pending || service_call_pending)
    |=> avs_readdata[`IRQ_FLAG_BIT])
    else $error("interrupt pending flag clear with one pending");

  a_reset_req_sticky: assert property (
    @(posedge mclk) disable iff (!rst_n)
    system_reset_request |=> system_reset_request)
    else $error("reset request dropped before reset");

  a_ics_reserved_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    avs_read && !avs_waitrequest && avs_address == `ICS_OFFSET
    |-> avs_readdata[31:29] == 3'h0 && !avs_readdata[27]
        && avs_readdata[25:24] == 2'h0 && avs_readdata[21:18] == 4'h0
        && avs_readdata[11:6] == 6'h00)
    else $error("reserved or write-only bits read nonzero");

endmodule // exception_state_reset_ctrl

//--- core_model.sv
`timescale 1ns/1ps

// ==========
// Core stand-in: takes exceptions, drops them on clear-active
module core_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Commands from the bench, and clear_active_state from the controller
  input  wire logic       do_tick,
  input  wire logic       do_enter,
  input  wire logic [5:0] enter_num,
  input  wire logic       clear_active_state,
  input  wire logic       stack_init,
  // Core-side signals
  output logic            tick_event,
  output logic            exc_entry,
  output logic      [5:0] exc_entry_number,
  output logic      [5:0] core_active_vector,
  output logic      [3:0] stack_depth
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_event <= 1'b0;
      exc_entry <= 1'b0;
      exc_entry_number <= 6'h00;
    end else begin
      tick_event <= do_tick;
      exc_entry <= do_enter;
      // Number is only meaningful with the strobe; scrambled otherwise
      exc_entry_number <= do_enter ? enter_num : ~exc_entry_number;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_active_vector <= 6'h00;
    end else if (clear_active_state) begin
      core_active_vector <= 6'h00;
    end else if (do_enter) begin
      core_active_vector <= enter_num;
    end
  end

  // Clear-active leaves the frames in place; only reset or the debugger's
  // re-initialisation empties the stack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stack_depth <= 4'h0;
    end else if (stack_init) begin
      stack_depth <= 4'h0;
    end else if (do_enter) begin
      stack_depth <= stack_depth + 4'h1;
    end
  end
endmodule // core_model

//--- tb.sv
`timescale 1ns/1ps
`include "exc_params.svh"

`define CHK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end \
end

module tb;
  // ==========
  // Signals
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        do_tick = 1'b0;
  logic        do_enter = 1'b0;
  logic [5:0]  enter_num = 6'h00;
  logic        core_halted = 1'b0;
  logic        stack_init = 1'b0;
  logic [3:0]  stack_depth;
  logic [31:0] ext_irq_pending = 32'h00000000;
  logic [31:0] ext_irq_enable = 32'h00000000;
  logic [63:0] ext_irq_priority = 64'h0;
  logic [1:0]  tick_priority = 2'h1;
  logic [1:0]  service_priority = 2'h0;
  logic        tick_event, exc_entry, clear_active_state;
  logic [5:0]  exc_entry_number, core_active_vector, pending_vector_number;
  logic        tick_pending, service_call_pending, system_reset_request, irq;
  logic [31:0] rd;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;

  core_model core_u (.mclk, .rst_n, .do_tick, .do_enter, .enter_num,
    .clear_active_state, .tick_event, .exc_entry, .exc_entry_number,
    .core_active_vector, .stack_init, .stack_depth);

  exception_state_reset_ctrl dut_u (.mclk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .tick_event, .exc_entry, .exc_entry_number,
    .core_halted, .core_active_vector, .ext_irq_pending, .ext_irq_enable,
    .ext_irq_priority, .tick_priority, .service_priority, .tick_pending,
    .service_call_pending, .pending_vector_number, .system_reset_request,
    .clear_active_state, .irq);

  always #25 mclk = ~mclk;

  // ==========
  // Helpers
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction

  function automatic logic [31:0] vec(input logic [5:0] v);
    return {26'h0, v} << `PEND_VEC_LSB;
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Called just after a rising edge; the answer is taken at the rising
  // edge where waitrequest is seen low, and only the bench timeout ends
  // a wait that never finishes
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask

  task automatic pulse_tick;
    do_tick <= 1'b1;
    @(posedge mclk);
    do_tick <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      $display("ERROR timeout expected 0 seen 1");
      report_and_stop;
    end
  end

  // ==========
  // Tests
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rdchk("reset ctrl", `AIRC_OFFSET, '1, `AIRC_RESET);
    rdchk("ics idle", `ICS_OFFSET, '1, 32'h0);
    rdchk("unmapped", 12'h100, '1, 32'h0);
    wr(`EVT_MASK_OFFSET, 32'h7);
    wr(`ICS_OFFSET, b(`TICK_SET_BIT) | 32'h60000fc0);
    rdchk("tick set", `ICS_OFFSET, '1, b(26) | b(22) | vec(6'h0f));
    `CHK("pending port", `TICK_EXC_NUM, pending_vector_number)
    `CHK("irq on", 1'b1, irq)
    wr(`ICS_OFFSET, 32'h0);
    rdchk("zero write", `ICS_OFFSET, b(26), b(26));
    wr(`ICS_OFFSET, b(`SVC_SET_BIT));
    rdchk("svc set", `ICS_OFFSET, '1,
          b(28) | b(26) | b(22) | vec(6'h0e));
    `CHK("svc port", 1'b1, service_call_pending)
    rdchk("events", `EVT_STATUS_OFFSET, 32'h3, 32'h3);
    wr(`ICS_OFFSET, b(`TICK_CLR_BIT));
    rdchk("tick clear", `ICS_OFFSET, '1, b(28) | b(22) | vec(6'h0e));
    wr(`ICS_OFFSET, b(`SVC_CLR_BIT));
    rdchk("svc clear", `ICS_OFFSET, '1, 32'h0);
    // Top byte disabled: the set must be dropped
    avs_byteenable <= 4'h7;
    wr(`ICS_OFFSET, b(`TICK_SET_BIT));
    avs_byteenable <= 4'hf;
    rdchk("partial write", `ICS_OFFSET, '1, 32'h0);
    wr(`EVT_STATUS_OFFSET, 32'h3);
    `CHK("irq w1c", 1'b0, irq)
    wr(`EVT_MASK_OFFSET, 32'h0);
    pulse_tick;
    `CHK("tick event", 1'b1, tick_pending)
    `CHK("irq masked", 1'b0, irq)
    wr(`EVT_MASK_OFFSET, 32'h1);
    `CHK("irq unmasked", 1'b1, irq)
    wr(`EVT_STATUS_OFFSET, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
    core_halted <= 1'b1;
    repeat (2) @(posedge mclk);
    rdchk("debug flag", `ICS_OFFSET, b(23), b(23));
    do_enter <= 1'b1;
    enter_num <= `TICK_EXC_NUM;
    @(posedge mclk);
    do_enter <= 1'b0;
    repeat (2) @(posedge mclk);
    rdchk("active", `ICS_OFFSET, '1, 32'h0000000f);
    ext_irq_pending <= b(3) | b(1);
    ext_irq_enable <= b(3);
    repeat (3) @(posedge mclk);
    rdchk("ext irq", `ICS_OFFSET, '1,
          b(23) | b(22) | vec(6'h13) | 32'hf);
    ext_irq_pending <= 32'h0;
    // Clear-active only while halted
    wr(`AIRC_OFFSET, {`WRITE_KEY, 16'h0002});
    rdchk("clear active", `ICS_OFFSET, 32'h3f, 32'h0);
    stack_init <= 1'b1;
    @(posedge mclk);
    stack_init <= 1'b0;
    @(posedge mclk);
    `CHK("stack reinit", 4'h0, stack_depth)
    wr(`AIRC_OFFSET, b(`SYSRST_BIT));
    `CHK("unkeyed", 1'b0, system_reset_request)
    rdchk("bad key", `EVT_STATUS_OFFSET, b(2), b(2));
    wr(`AIRC_OFFSET, {`WRITE_KEY, 16'h0004});
    repeat (4) @(posedge mclk);
    `CHK("reset req", 1'b1, system_reset_request)
    rdchk("write only", `AIRC_OFFSET, '1, `AIRC_RESET);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK("req cleared", 1'b0, system_reset_request)
    report_and_stop;
  end
endmodule // tb
